// [verilog/smbsl_master.sv]
// master end: makes scl, sends start, bytes and stop
`timescale 1ns/1ps
module smbsl_master
    import smbsl_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       rstn_in,
    smbsl_if.master         bus,
    input  wire logic       cmd_valid_in,
    input  wire smbsl_cmd_t cmd_kind_in,
    input  wire logic [6:0] cmd_addr_in,
    input  wire logic [7:0] cmd_ptr_in,
    input  wire logic [7:0] cmd_data_in,
    output logic            cmd_ready_out,
    output logic            done_out,
    output logic            nack_out,
    output logic      [7:0] rd_data_out
);
    smbsl_mst_t state_q, state_d;
    logic [7:0] cnt_q;
    logic [1:0] qtr_q, qtr_d;
    logic [3:0] bit_q, bit_d;
    logic [1:0] byte_q, byte_d, last_q, last_d;
    logic       is_rd_q, is_rd_d;
    logic [7:0] tx_q, tx_d, ptr_q, ptr_d, data_q, data_d, rx_q, rx_d, rd_q, rd_d;
    logic       scl_q, scl_d, oe_q, oe_d, nack_q, nack_d, done_q, done_d, ready_q;
    logic       sda_s;

    smbsl_sync #(.W(1)) u_sync (
        .clk_in  (clk_in),
        .rstn_in (rstn_in),
        .d_in    (bus.sda),
        .q_out   (sda_s)
    );

    wire tick    = cnt_q == QTR_LAST;
    wire rx_byte = is_rd_q & (byte_q != BYTE_ADDR);
    wire [7:0] cnt_d = (state_q == M_IDLE || tick) ? 8'h00 : cnt_q + 8'h01;

    always_comb begin
        state_d = state_q;
        qtr_d   = qtr_q;
        bit_d   = bit_q;
        byte_d  = byte_q;
        last_d  = last_q;
        is_rd_d = is_rd_q;
        tx_d    = tx_q;
        ptr_d   = ptr_q;
        data_d  = data_q;
        rx_d    = rx_q;
        rd_d    = rd_q;
        scl_d   = scl_q;
        oe_d    = oe_q;
        nack_d  = nack_q;
        done_d  = 1'b0;
        case (state_q)
            M_IDLE: if (cmd_valid_in) begin
                state_d = M_START;
                qtr_d   = 2'h0;
                nack_d  = 1'b0;
                is_rd_d = cmd_kind_in == SMBSL_CMD_READ;
                tx_d    = {cmd_addr_in, cmd_kind_in == SMBSL_CMD_READ};
                ptr_d   = cmd_ptr_in;
                data_d  = cmd_data_in;
                last_d  = (cmd_kind_in == SMBSL_CMD_WRITE) ? BYTE_SECOND : BYTE_FIRST;
            end
            M_START: if (tick) begin
                qtr_d = qtr_q + 2'h1;
                if (qtr_q == 2'h0) begin
                    oe_d = 1'b1;
                end else begin
                    scl_d   = 1'b0;
                    state_d = M_BITS;
                    qtr_d   = 2'h0;
                    bit_d   = 4'h0;
                    byte_d  = BYTE_ADDR;
                end
            end
            M_BITS: if (tick) begin
                qtr_d = qtr_q + 2'h1;
                case (qtr_q)
                    2'h0: oe_d = ~rx_byte & (bit_q != ACK_BIT) & ~tx_q[7];
                    2'h1: scl_d = 1'b1;
                    2'h3: begin
                        scl_d = 1'b0;
                        bit_d = bit_q + 4'h1;
                        if (bit_q != ACK_BIT) begin
                            tx_d = {tx_q[6:0], 1'b0};
                            rx_d = {rx_q[6:0], sda_s};
                        end else begin
                            bit_d  = 4'h0;
                            byte_d = byte_q + 2'h1;
                            tx_d   = (byte_q == BYTE_ADDR) ? ptr_q : data_q;
                            if (~rx_byte & sda_s) begin
                                nack_d  = 1'b1;
                                state_d = M_STOP;
                            end else if (byte_q == last_q) begin
                                state_d = M_STOP;
                                rd_d    = is_rd_q ? rx_q : rd_q;
                            end
                        end
                    end
                    default: ;
                endcase
            end
            M_STOP: if (tick) begin
                qtr_d = qtr_q + 2'h1;
                case (qtr_q)
                    2'h0: oe_d = 1'b1;
                    2'h1: scl_d = 1'b1;
                    2'h2: oe_d = 1'b0;
                    default: begin
                        state_d = M_IDLE;
                        done_d  = 1'b1;
                    end
                endcase
            end
            default: state_d = M_IDLE;
        endcase
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_q <= M_IDLE;
            cnt_q   <= 8'h00;
            qtr_q   <= 2'h0;
            bit_q   <= 4'h0;
            byte_q  <= BYTE_ADDR;
            last_q  <= BYTE_FIRST;
            is_rd_q <= 1'b0;
            tx_q    <= 8'h00;
            ptr_q   <= 8'h00;
            data_q  <= 8'h00;
            rx_q    <= 8'h00;
            rd_q    <= 8'h00;
            scl_q   <= 1'b1;
            oe_q    <= 1'b0;
            nack_q  <= 1'b0;
            done_q  <= 1'b0;
            ready_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            qtr_q   <= qtr_d;
            bit_q   <= bit_d;
            byte_q  <= byte_d;
            last_q  <= last_d;
            is_rd_q <= is_rd_d;
            tx_q    <= tx_d;
            ptr_q   <= ptr_d;
            data_q  <= data_d;
            rx_q    <= rx_d;
            rd_q    <= rd_d;
            scl_q   <= scl_d;
            oe_q    <= oe_d;
            nack_q  <= nack_d;
            done_q  <= done_d;
            ready_q <= state_d == M_IDLE;
        end
    end

    assign bus.scl       = scl_q;
    assign bus.m_sda_o   = 1'b0;
    assign bus.m_sda_oe  = oe_q;
    assign cmd_ready_out = ready_q;
    assign done_out      = done_q;
    assign nack_out      = nack_q;
    assign rd_data_out   = rd_q;
endmodule : smbsl_master

// [inc/smbsl_pkg.sv]
// shared constants and types for the two-wire slave link
package smbsl_pkg;
    localparam logic [4:0] SLV_ADDR_HI   = 5'h0b;
    localparam logic [6:0] SLV_ADDR_RST  = 7'h2c;
    localparam logic [1:0] STRAP_LATCH   = 2'h2;
    localparam logic [1:0] STRAP_DONE    = 2'h3;
    localparam logic [3:0] LAST_DATA_BIT = 4'h7;
    localparam logic [3:0] ACK_BIT       = 4'h8;
    localparam logic [1:0] BYTE_ADDR     = 2'h0;
    localparam logic [1:0] BYTE_FIRST    = 2'h1;
    localparam logic [1:0] BYTE_SECOND   = 2'h2;
    localparam logic [1:0] BYTE_EXTRA    = 2'h3;
    localparam int         CLK_PERIOD_NS = 100;
    localparam int         SCL_PERIOD_NS = 10000;
    localparam int         QTR_CYC       = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
    localparam logic [7:0] QTR_LAST      = 8'(QTR_CYC - 1);

    typedef enum logic [1:0] {
        SMBSL_CMD_PTR   = 2'h0,
        SMBSL_CMD_WRITE = 2'h1,
        SMBSL_CMD_READ  = 2'h2
    } smbsl_cmd_t;

    typedef enum logic [1:0] {
        M_IDLE  = 2'h0,
        M_START = 2'h1,
        M_BITS  = 2'h3,
        M_STOP  = 2'h2
    } smbsl_mst_t;
endpackage : smbsl_pkg

// [inc/smbsl_if.sv]
// two-wire link between master end and slave end
`timescale 1ns/1ps
interface smbsl_if;
    logic      scl;
    logic      m_sda_o;
    logic      m_sda_oe;
    logic      d_sda_o;
    logic      d_sda_oe;
    wire logic sda;

    // open drain with pull-up
    assign sda = !((m_sda_oe && !m_sda_o) || (d_sda_oe && !d_sda_o));

    modport master (output scl, m_sda_o, m_sda_oe, input sda);
    modport device (input scl, sda, output d_sda_o, d_sda_oe);
endinterface : smbsl_if

// [verilog/smbsl_sync.sv]
// two flip-flop level synchroniser
`timescale 1ns/1ps
module smbsl_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_in,
    input  wire logic         rstn_in,
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            meta_q <= '0;
            q_out  <= '0;
        end else begin
            meta_q <= d_in;
            q_out  <= meta_q;
        end
    end
endmodule : smbsl_sync

// [verilog/smbsl_device.sv]
// slave end: start/stop detect, address match, pointer and data strobes
`timescale 1ns/1ps
module smbsl_device
    import smbsl_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       rstn_in,
    smbsl_if.device         bus,
    input  wire logic       nand_tree_out_or_id_strap_pin_pu_in,
    input  wire logic       nand_tree_out_or_id_strap_pin_pd_in,
    input  wire logic [7:0] rd_data_in,
    output logic      [7:0] ptr_out,
    output logic      [7:0] wr_data_out,
    output logic            wr_stb_out,
    output logic            rd_stb_out,
    output logic      [6:0] slave_addr_out
);

    // ---------------- system clock side ----------------
    logic       scl_s;
    logic       sda_s;
    logic       wr_tgl_s;
    logic       rd_tgl_s;
    logic       pu_s;
    logic       pd_s;
    logic       scl_p_q;
    logic       sda_p_q;
    logic       wr_p_q;
    logic       rd_p_q;
    logic       link_rst_q;
    logic       armed_q;
    logic [1:0] strap_cnt_q;
    logic [6:0] slv_addr_q;
    logic [7:0] ptr_q;
    logic [7:0] wr_data_q;
    logic       wr_stb_q;
    logic       rd_stb_q;
    logic [7:0] rd_hold_q;

    // ---------------- link clock side ----------------
    logic [3:0] bit_q;
    logic [1:0] byte_no_q;
    logic [6:0] sh_q;
    logic       matched_q;
    logic       read_q;
    logic [7:0] rx_byte_q;
    logic       kind_data_q;
    logic       wr_tgl_q;
    logic       rd_tgl_q;
    logic       sda_oe_q;

    smbsl_sync #(.W(6)) u_sync (
        .clk_in  (clk_in),
        .rstn_in (rstn_in),
        .d_in    ({bus.scl, bus.sda, wr_tgl_q, rd_tgl_q,
                   nand_tree_out_or_id_strap_pin_pu_in, nand_tree_out_or_id_strap_pin_pd_in}),
        .q_out   ({scl_s, sda_s, wr_tgl_s, rd_tgl_s, pu_s, pd_s})
    );

    wire start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
    wire stop_det  = scl_s & scl_p_q & ~sda_p_q & sda_s;

    // link logic held in reset outside frames, released once scl goes low
    wire link_rst_d = (start_det | stop_det) ? 1'b1 :
                      (armed_q & ~scl_s)     ? 1'b0 : link_rst_q;
    wire armed_d    = start_det ? 1'b1 : ((stop_det | ~scl_s) ? 1'b0 : armed_q);

    // open strap: pull-up sees high, pull-down sees low
    wire strap_bit_upper = ~pu_s & ~pd_s;
    wire strap_bit_lower = pu_s & pd_s;
    wire strap_latch     = strap_cnt_q == STRAP_LATCH;
    wire [1:0] strap_cnt_d = (strap_cnt_q == STRAP_DONE) ? strap_cnt_q : strap_cnt_q + 2'h1;
    wire [6:0] slv_addr_d  = strap_latch ? {SLV_ADDR_HI, strap_bit_upper, strap_bit_lower}
                                         : slv_addr_q;

    wire wr_evt = wr_tgl_s ^ wr_p_q;
    wire rd_evt = rd_tgl_s ^ rd_p_q;
    wire [7:0] ptr_d     = (wr_evt & ~kind_data_q) ? rx_byte_q : ptr_q;
    wire [7:0] wr_data_d = (wr_evt & kind_data_q) ? rx_byte_q : wr_data_q;
    wire [7:0] rd_hold_d = rd_evt ? rd_data_in : rd_hold_q;

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            scl_p_q     <= 1'b1;
            sda_p_q     <= 1'b1;
            wr_p_q      <= 1'b0;
            rd_p_q      <= 1'b0;
            link_rst_q  <= 1'b1;
            armed_q     <= 1'b0;
            strap_cnt_q <= 2'h0;
            slv_addr_q  <= SLV_ADDR_RST;
            ptr_q       <= 8'h00;
            wr_data_q   <= 8'h00;
            wr_stb_q    <= 1'b0;
            rd_stb_q    <= 1'b0;
            rd_hold_q   <= 8'h00;
        end else begin
            scl_p_q     <= scl_s;
            sda_p_q     <= sda_s;
            wr_p_q      <= wr_tgl_s;
            rd_p_q      <= rd_tgl_s;
            link_rst_q  <= link_rst_d;
            armed_q     <= armed_d;
            strap_cnt_q <= strap_cnt_d;
            slv_addr_q  <= slv_addr_d;
            ptr_q       <= ptr_d;
            wr_data_q   <= wr_data_d;
            wr_stb_q    <= wr_evt & kind_data_q;
            rd_stb_q    <= rd_evt;
            rd_hold_q   <= rd_hold_d;
        end
    end

    assign ptr_out        = ptr_q;
    assign wr_data_out    = wr_data_q;
    assign wr_stb_out     = wr_stb_q;
    assign rd_stb_out     = rd_stb_q;
    assign slave_addr_out = slv_addr_q;

    // ---------------- link logic, rising scl ----------------
    wire [7:0] byte_in   = {sh_q, bus.sda};
    wire       last_bit  = bit_q == LAST_DATA_BIT;
    wire       ack_slot  = bit_q == ACK_BIT;
    wire       byte_zero = byte_no_q == BYTE_ADDR;
    wire       wr_range  = (byte_no_q == BYTE_FIRST) | (byte_no_q == BYTE_SECOND);
    wire       addr_hit  = byte_in[7:1] == slv_addr_q;
    wire       addr_done = last_bit & byte_zero;
    wire       wr_byte   = last_bit & matched_q & ~read_q & wr_range;

    wire [3:0] bit_d      = ack_slot ? 4'h0 : bit_q + 4'h1;
    wire [1:0] byte_no_d  = (ack_slot && byte_no_q != BYTE_EXTRA) ? byte_no_q + 2'h1 : byte_no_q;
    wire       matched_d  = addr_done ? addr_hit : matched_q;
    wire       read_d     = addr_done ? bus.sda : read_q;
    wire [7:0] rx_byte_d  = wr_byte ? byte_in : rx_byte_q;
    wire       kind_d     = wr_byte ? (byte_no_q == BYTE_SECOND) : kind_data_q;
    wire       wr_tgl_d   = wr_tgl_q ^ wr_byte;
    wire       rd_tgl_d   = rd_tgl_q ^ (addr_done & addr_hit & bus.sda);

    always_ff @(posedge bus.scl or posedge link_rst_q) begin
        if (link_rst_q) begin
            bit_q       <= 4'h0;
            byte_no_q   <= BYTE_ADDR;
            sh_q        <= 7'h00;
            matched_q   <= 1'b0;
            read_q      <= 1'b0;
        end else begin
            bit_q       <= bit_d;
            byte_no_q   <= byte_no_d;
            sh_q        <= byte_in[6:0];
            matched_q   <= matched_d;
            read_q      <= read_d;
        end
    end

    // byte and toggles survive frame resets so the other side sees them settle
    always_ff @(posedge bus.scl or negedge rstn_in) begin
        if (!rstn_in) begin
            rx_byte_q   <= 8'h00;
            kind_data_q <= 1'b0;
            wr_tgl_q    <= 1'b0;
            rd_tgl_q    <= 1'b0;
        end else begin
            rx_byte_q   <= rx_byte_d;
            kind_data_q <= kind_d;
            wr_tgl_q    <= wr_tgl_d;
            rd_tgl_q    <= rd_tgl_d;
        end
    end

    // ---------------- link logic, falling scl ----------------
    // rd_hold_q is loaded almost one and a half scl periods before its first use
    wire ack_want = matched_q & (byte_zero | (~read_q & wr_range));
    wire rd_slot  = matched_q & read_q & (byte_no_q == BYTE_FIRST) & ~ack_slot;
    wire rd_bit   = rd_hold_q[3'(LAST_DATA_BIT - bit_q)];
    wire sda_oe_d = ack_slot ? ack_want : (rd_slot & ~rd_bit);

    always_ff @(negedge bus.scl or posedge link_rst_q) begin
        if (link_rst_q) begin
            sda_oe_q <= 1'b0;
        end else begin
            sda_oe_q <= sda_oe_d;
        end
    end

    assign bus.d_sda_o  = 1'b0;
    assign bus.d_sda_oe = sda_oe_q;

endmodule : smbsl_device

// [verification/smbsl_assertions.sv]
// concurrent checks on the two-wire link between master end and device end
`timescale 1ns/1ps
module smbsl_assertions
    import smbsl_pkg::*;
#(
    parameter logic [6:0] SLV_ADDR = SLV_ADDR_RST
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic scl,
    input wire logic sda,
    input wire logic m_sda_o,
    input wire logic m_sda_oe,
    input wire logic d_sda_o,
    input wire logic d_sda_oe
);
    logic       scl_q;
    logic       sda_q;
    logic [5:0] bitn_q;
    logic [7:0] sh_q;
    logic [7:0] abyte_q;
    wire        rise  = scl && !scl_q;
    wire        start = scl && scl_q && sda_q && !sda;
    wire        stop  = scl && scl_q && !sda_q && sda;
    wire        match = abyte_q[7:1] == SLV_ADDR;
    wire        wr_fr = match && !abyte_q[0];

    // bit count since start, address byte capture
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            scl_q   <= 1'b1;
            sda_q   <= 1'b1;
            bitn_q  <= 6'h00;
            sh_q    <= 8'hff;
            abyte_q <= 8'hff;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
            sh_q  <= rise ? {sh_q[6:0], sda} : sh_q;
            if (start) begin
                bitn_q <= 6'h00;
            end else if (rise && bitn_q != 6'h3f) begin
                bitn_q <= bitn_q + 6'h01;
            end
            if (rise && bitn_q == 6'h07) begin
                abyte_q <= {sh_q[6:0], sda};
            end
        end
    end

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rstn_in);

    AST_ACK_ON_MATCH: assert property (rise && bitn_q == 6'h08 && match |-> !sda)
        else $error("address acknowledge missing");
    AST_NO_ACK_MISMATCH: assert property (bitn_q >= 6'h08 && !match |-> !d_sda_oe)
        else $error("device drives in a frame for another address");
    AST_WRITE_BYTE_ACK: assert property (rise && wr_fr && (bitn_q == 6'h11 || bitn_q == 6'h1a) |-> !sda)
        else $error("write byte not acknowledged");
    AST_READ_NACK_RELEASED: assert property (rise && match && abyte_q[0] && bitn_q == 6'h11 |-> sda)
        else $error("sda held low in read acknowledge slot");
    AST_WRITE_DATA_QUIET: assert property (wr_fr && bitn_q inside {[6'h0a:6'h10]} |-> !d_sda_oe)
        else $error("device drives during written data bits");
    AST_STOP_RELEASE: assert property (stop |=> (!d_sda_oe) [*8])
        else $error("device drives after stop");
    AST_DEV_CHANGE_SCL_LOW: assert property ($changed(d_sda_oe) |-> !scl)
        else $error("device changes sda while scl high");
    AST_IDLE_DURING_ADDR: assert property (bitn_q < 6'h08 |-> !d_sda_oe)
        else $error("device drives during address bits");
    AST_READ_MASTER_QUIET: assert property (match && abyte_q[0] && bitn_q inside {[6'h09:6'h11]} |-> !m_sda_oe)
        else $error("master drives during read byte or its acknowledge");

    COV_WRITE_ACK: cover property (rise && wr_fr && bitn_q == 6'h1a && !sda);
    COV_READ: cover property (rise && match && abyte_q[0] && bitn_q == 6'h11);
    COV_MISMATCH: cover property (rise && bitn_q == 6'h08 && !match && sda);
endmodule : smbsl_assertions

// [verification/tb_top.sv]
// self-checking bench: master end talks to device end over the shared link
`timescale 1ns/1ps
module tb_top
    import smbsl_pkg::*;
;
    logic       clk_in = 1'b0;
    logic       rstn_in = 1'b0;
    logic       cmd_valid = 1'b0;
    smbsl_cmd_t cmd_kind = SMBSL_CMD_PTR;
    logic [6:0] cmd_addr = 7'h00;
    logic [7:0] cmd_ptr = 8'h00;
    logic [7:0] cmd_data = 8'h00;
    logic       strap_pu = 1'b1;
    logic       strap_pd = 1'b0;
    logic       cmd_ready, done, nack, wr_stb, rd_stb;
    logic [6:0] slave_addr;
    logic [7:0] ptr, wr_data, rd_data, wire_sh;
    logic [7:0] wire_byte [4];
    logic       wire_ack [4];
    int         bit_cnt = 0, wr_cnt = 0, rd_cnt = 0, err_count = 0, samples_checked = 0;
    // register file model seen by the device
    wire  [7:0] reg_rd = ptr ^ 8'hc3;

    always #(CLK_PERIOD_NS / 2) clk_in = ~clk_in;

    smbsl_if smbsl_if_i ();
    smbsl_master smbsl_master_i (.clk_in(clk_in), .rstn_in(rstn_in), .bus(smbsl_if_i), .cmd_valid_in(cmd_valid),
        .cmd_kind_in(cmd_kind), .cmd_addr_in(cmd_addr), .cmd_ptr_in(cmd_ptr), .cmd_data_in(cmd_data),
        .cmd_ready_out(cmd_ready), .done_out(done), .nack_out(nack), .rd_data_out(rd_data));
    smbsl_device smbsl_device_i (.clk_in(clk_in), .rstn_in(rstn_in), .bus(smbsl_if_i),
        .nand_tree_out_or_id_strap_pin_pu_in(strap_pu), .nand_tree_out_or_id_strap_pin_pd_in(strap_pd),
        .rd_data_in(reg_rd), .ptr_out(ptr), .wr_data_out(wr_data), .wr_stb_out(wr_stb), .rd_stb_out(rd_stb),
        .slave_addr_out(slave_addr));
    smbsl_assertions smbsl_assertions_i (.clk_in(clk_in), .rstn_in(rstn_in), .scl(smbsl_if_i.scl),
        .sda(smbsl_if_i.sda), .m_sda_o(smbsl_if_i.m_sda_o), .m_sda_oe(smbsl_if_i.m_sda_oe),
        .d_sda_o(smbsl_if_i.d_sda_o), .d_sda_oe(smbsl_if_i.d_sda_oe));

    always @(negedge clk_in) begin
        wr_cnt += (wr_stb === 1'b1);
        rd_cnt += (rd_stb === 1'b1);
    end

    // wire monitor: bytes and ack bits of the current frame
    always @(negedge smbsl_if_i.sda) begin
        if (smbsl_if_i.scl === 1'b1) bit_cnt = 0;
    end
    always @(posedge smbsl_if_i.scl) begin
        if (bit_cnt < 36) begin
            if (bit_cnt % 9 == 8) wire_ack[bit_cnt / 9] = smbsl_if_i.sda;
            else wire_sh = {wire_sh[6:0], smbsl_if_i.sda};
            if (bit_cnt % 9 == 7) wire_byte[bit_cnt / 9] = wire_sh;
            bit_cnt++;
        end
    end

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test

    task automatic do_reset();
        rstn_in = 1'b0;
        repeat (6) @(posedge clk_in);
        #1 rstn_in = 1'b1;
        repeat (6) @(posedge clk_in);
        #1;
    endtask : do_reset

    task automatic run_cmd(input smbsl_cmd_t kind, input logic [6:0] addr, input logic [7:0] p, input logic [7:0] d);
        int n = 0;
        while (cmd_ready !== 1'b1 && n < 100) begin
            @(posedge clk_in);
            #1 n++;
        end
        wire_byte = '{default: 8'hxx};
        wire_ack = '{default: 1'bx};
        check("ready", {7'h00, cmd_ready}, 8'h01);
        cmd_valid = 1'b1;
        cmd_kind = kind;
        cmd_addr = addr;
        cmd_ptr = p;
        cmd_data = d;
        @(posedge clk_in);
        #1 cmd_valid = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 4000) begin
            @(posedge clk_in);
            #1 n++;
        end
        check("done", {7'h00, done}, 8'h01);
    endtask : run_cmd

    task automatic test_strap();
        logic [1:0] sel [4] = '{2'b00, 2'b11, 2'b01, 2'b10};
        logic [1:0] low [4] = '{2'h2, 2'h1, 2'h0, 2'h0};
        for (int k = 0; k < 4; k++) begin
            {strap_pu, strap_pd} = sel[k];
            do_reset();
            check("slave addr", {1'b0, slave_addr}, {1'b0, SLV_ADDR_HI, low[k]});
            {strap_pu, strap_pd} = ~sel[k];
            repeat (8) @(posedge clk_in);
            #1;
            check("addr after strap change", {1'b0, slave_addr}, {1'b0, SLV_ADDR_HI, low[k]});
        end
        check("ptr reset", ptr, 8'h00);
        $display("test_strap done");
    endtask : test_strap

    task automatic test_write(input logic [7:0] p, input logic [7:0] d);
        int w0 = wr_cnt;
        run_cmd(SMBSL_CMD_WRITE, SLV_ADDR_RST, p, d);
        check("nack", {7'h00, nack}, 8'h00);
        check("addr byte", wire_byte[0], {SLV_ADDR_RST, 1'b0});
        check("data byte", wire_byte[2], d);
        check("data ack", {7'h00, wire_ack[2]}, 8'h00);
        check("ptr", ptr, p);
        check("wr data", wr_data, d);
        check("wr count", 8'(wr_cnt - w0), 8'h01);
        check("idle lines", {6'h00, smbsl_if_i.scl, smbsl_if_i.sda}, 8'h03);
        $display("test_write done");
    endtask : test_write

    task automatic test_ptr(input logic [7:0] p, input logic [7:0] prev);
        int w0 = wr_cnt;
        run_cmd(SMBSL_CMD_PTR, SLV_ADDR_RST, p, 8'h99);
        check("nack", {7'h00, nack}, 8'h00);
        check("ptr only", ptr, p);
        check("wr count", 8'(wr_cnt - w0), 8'h00);
        check("wr data kept", wr_data, prev);
        $display("test_ptr done");
    endtask : test_ptr

    task automatic test_read(input logic [7:0] p);
        int r0 = rd_cnt;
        run_cmd(SMBSL_CMD_READ, SLV_ADDR_RST, 8'h00, 8'h00);
        check("addr byte", wire_byte[0], {SLV_ADDR_RST, 1'b1});
        check("nack", {7'h00, nack}, 8'h00);
        check("rd data", rd_data, p ^ 8'hc3);
        check("wire read byte", wire_byte[1], p ^ 8'hc3);
        check("read nack slot", {7'h00, wire_ack[1]}, 8'h01);
        check("rd count", 8'(rd_cnt - r0), 8'h01);
        check("ptr kept", ptr, p);
        $display("test_read done");
    endtask : test_read

    task automatic test_mismatch(input logic [6:0] addr);
        logic [7:0] p0 = ptr;
        int w0 = wr_cnt;
        run_cmd(SMBSL_CMD_WRITE, addr, 8'h11, 8'h22);
        check("nack", {7'h00, nack}, 8'h01);
        check("addr ack bit", {7'h00, wire_ack[0]}, 8'h01);
        check("ptr kept", ptr, p0);
        check("wr count", 8'(wr_cnt - w0), 8'h00);
        $display("test_mismatch done");
    endtask : test_mismatch

    initial begin
        #6_000_000;
        err_count++;
        $display("watchdog expired");
        finish_test();
    end

    initial begin
        test_strap();
        test_write(8'ha5, 8'h3c);
        test_ptr(8'h5a, 8'h3c);
        test_read(8'h5a);
        test_read(8'h5a);
        test_mismatch(7'h2d);
        test_mismatch(7'h6c);
        test_write(8'hff, 8'h00);
        test_read(8'hff);
        finish_test();
    end
endmodule : tb_top
